/* File: include/rsg_pkg.sv */
`default_nettype none
package rsg_pkg;
  // ****************************
  // Register map and fields
  // ****************************
  localparam int          AXI_AW      = 4;
  localparam logic [3:0]  OFF_RESCFG  = 4'h0;
  localparam logic [3:0]  OFF_PLLMULT = 4'h4;
  localparam logic [3:0]  OFF_SYSDIV  = 4'h8;
  localparam logic [3:0]  OFF_STATUS  = 4'hC;
  localparam int          CTRL_REL_B  = 0;
  localparam int          ANA_REL_B   = 1;
  localparam int          IMULT_W     = 7;
  localparam int          IMULT_LSB   = 0;
  localparam int          FMULT_W     = 2;
  localparam int          FMULT_LSB   = 8;
  localparam int          DIV_W       = 3;
  localparam int          CNT_W       = 7;
  localparam logic [6:0]  IMULT_BYP   = 7'h00;
  localparam logic [6:0]  IMULT_RST   = 7'h00;
  localparam logic [1:0]  FMULT_RST   = 2'h0;
  localparam logic [2:0]  DIV_RST     = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef struct packed {
    logic por_n;
    logic irqc_n;
    logic wdog0_n;
    logic wdog1_n;
    logic nmi_wdog_n;
  } rsg_rst_req_s;

  typedef struct packed {
    logic                awrdy;
    logic                wrdy;
    logic                arrdy;
    logic                aw_full;
    logic [AXI_AW-1:0]   aw_addr;
    logic                w_full;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                ctrl_rel;
    logic                ana_rel;
    logic [IMULT_W-1:0]  imult;
    logic [FMULT_W-1:0]  fmult;
    logic [DIV_W-1:0]    div;
    logic                pll_en;
    logic                act_byp;
    logic [DIV_W-1:0]    act_div;
    logic                osc_q;
    logic                pll_q;
    logic                half;
    logic                src_q;
    logic [CNT_W-1:0]    cnt;
    logic                sysclk;
    logic                ars_oe;
    logic                xrs_oe;
    logic                master_rst_n;
    logic                ctrl_rst_n;
    logic                ana_rst_n;
    logic                gpio_hiz;
    logic                lp_fast;
    logic                lp_slow;
    logic                mcd_ref;
    logic                usb_ref;
    logic                can_clk;
  } rsg_state_s;
endpackage
`default_nettype wire

/* File: rtl/rsg_top.sv */
// Behaviour
// - Power-on reset drives both reset pins low, independent of regulators.
// - Power-on reset resets both subsystems and floats every GPIO.
// - Digital reset pin driven by AND of active-low requests and power-on reset.
// - Control and analog subsystems stay in reset until software sets release bits.
// - Reset pins open-drain; device stays in reset while digital pin held low; analog pin low resets only analog subsystem.
// - Internal oscillator clocks fixed; low-power clock outputs pass them only in low-power mode.
// - Fast internal oscillator clock is missing-clock detection reference.
// - Aux clock input feeds only USB PLL reference and CAN clocks.
// - PLL multiplies oscillator clock by integer plus fractional multiplier fields.
// - Raw PLL output halved, then muxed against undivided oscillator clock.
// - Integer multiplier zero selects bypass, passing the oscillator clock.
// - Integer codes one to thirty-one give factor equal to their value.
// - Codes thirty-two to one hundred twenty-seven likewise give their value.
// - Mux output passes system divider to become the main system clock.
`default_nettype none
module rsg_top (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_por_n,
  input  wire logic        i_irqc_rst_n,
  input  wire logic        i_wdog0_rst_n,
  input  wire logic        i_wdog1_rst_n,
  input  wire logic        i_nmi_wdog_rst_n,
  input  wire logic        i_ars_pin_in,
  output logic             o_ars_pin_out,
  output logic             o_ars_pin_oe,
  input  wire logic        i_xrs_pin_in,
  output logic             o_xrs_pin_out,
  output logic             o_xrs_pin_oe,
  output logic             o_master_rst_n,
  output logic             o_control_rst_n,
  output logic             o_analog_rst_n,
  output logic             o_gpio_hiz,
  input  wire logic        i_fast_osc_clk,
  input  wire logic        i_slow_osc_clk,
  input  wire logic        i_low_power,
  output logic             o_lp_fast_clk,
  output logic             o_lp_slow_clk,
  output logic             o_mcd_ref_clk,
  input  wire logic        i_aux_clk,
  output logic             o_usbpll_ref_clk,
  output logic             o_can_clk,
  input  wire logic        i_osc_clk,
  input  wire logic        i_pll_raw_clk,
  output logic [6:0]       o_pll_int_mult,
  output logic [1:0]       o_pll_frac_mult,
  output logic             o_pll_enable,
  output logic             o_sys_clk
);
  // ****************************
  // State
  // ****************************
  rsg_pkg::rsg_state_s     st;
  rsg_pkg::rsg_state_s     next_st;
  rsg_pkg::rsg_rst_req_s   req;
  logic                    dig_ok_n;
  logic                    src;
  logic                    nbyp;
  logic                    nsrc;
  logic [31:0]             rd_word;

  assign req = '{i_por_n, i_irqc_rst_n, i_wdog0_rst_n, i_wdog1_rst_n, i_nmi_wdog_rst_n};
  assign dig_ok_n = &req;

  function automatic logic [31:0] read_reg(input rsg_pkg::rsg_state_s s,
                                           input logic [3:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      rsg_pkg::OFF_RESCFG: begin
        v[rsg_pkg::CTRL_REL_B] = s.ctrl_rel;
        v[rsg_pkg::ANA_REL_B]  = s.ana_rel;
      end
      rsg_pkg::OFF_PLLMULT: begin
        v[rsg_pkg::IMULT_LSB +: rsg_pkg::IMULT_W] = s.imult;
        v[rsg_pkg::FMULT_LSB +: rsg_pkg::FMULT_W] = s.fmult;
      end
      rsg_pkg::OFF_SYSDIV: v[rsg_pkg::DIV_W-1:0] = s.div;
      rsg_pkg::OFF_STATUS: v[8:0] = {s.act_div, s.act_byp, s.sysclk, s.gpio_hiz,
                                     s.ana_rst_n, s.ctrl_rst_n, s.master_rst_n};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [3:0] a);
    return (a == rsg_pkg::OFF_RESCFG) || (a == rsg_pkg::OFF_PLLMULT) ||
           (a == rsg_pkg::OFF_SYSDIV) || (a == rsg_pkg::OFF_STATUS);
  endfunction

  assign rd_word = read_reg(st, i_araddr);

  // ****************************
  // Next state
  // ****************************
  always_comb begin
    next_st = st;
    src     = 1'b0;
    nbyp    = 1'b0;
    nsrc    = 1'b0;
    // Bus: channel releases before new captures
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_awvalid && st.awrdy) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && st.wrdy) begin
      next_st.w_full = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(st.aw_addr) ? rsg_pkg::RESP_OKAY : rsg_pkg::RESP_DECERR;
      case (st.aw_addr)
        rsg_pkg::OFF_RESCFG: begin
          if (st.w_strb[0]) begin
            next_st.ctrl_rel = st.w_data[rsg_pkg::CTRL_REL_B];
            next_st.ana_rel  = st.w_data[rsg_pkg::ANA_REL_B];
          end
        end
        rsg_pkg::OFF_PLLMULT: begin
          if (st.w_strb[0]) begin
            next_st.imult = st.w_data[rsg_pkg::IMULT_LSB +: rsg_pkg::IMULT_W];
          end
          if (st.w_strb[1]) begin
            next_st.fmult = st.w_data[rsg_pkg::FMULT_LSB +: rsg_pkg::FMULT_W];
          end
        end
        rsg_pkg::OFF_SYSDIV: begin
          if (st.w_strb[0]) begin
            next_st.div = st.w_data[rsg_pkg::DIV_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (i_arvalid && st.arrdy) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = mapped(i_araddr) ? rsg_pkg::RESP_OKAY : rsg_pkg::RESP_DECERR;
    end
    next_st.awrdy = !next_st.aw_full && !next_st.bvalid;
    next_st.wrdy  = !next_st.w_full && !next_st.bvalid;
    next_st.arrdy = !next_st.rvalid;

    // Reset pins and subsystem resets
    next_st.ars_oe       = !i_por_n;
    next_st.xrs_oe       = !dig_ok_n;
    next_st.gpio_hiz     = !i_por_n;
    next_st.master_rst_n = i_por_n && i_xrs_pin_in;
    if (!i_por_n || !i_xrs_pin_in) begin
      next_st.ctrl_rel = 1'b0;
      next_st.ana_rel  = 1'b0;
    end
    next_st.ctrl_rst_n = i_por_n && i_xrs_pin_in && st.ctrl_rel;
    next_st.ana_rst_n  = i_por_n && i_ars_pin_in && st.ana_rel;

    // Fixed clock routing
    next_st.lp_fast = i_fast_osc_clk && i_low_power;
    next_st.lp_slow = i_slow_osc_clk && i_low_power;
    next_st.mcd_ref = i_fast_osc_clk;
    next_st.usb_ref = i_aux_clk;
    next_st.can_clk = i_aux_clk;

    // System clock path
    next_st.pll_en = (st.imult != rsg_pkg::IMULT_BYP);
    next_st.osc_q  = i_osc_clk;
    next_st.pll_q  = i_pll_raw_clk;
    if (i_pll_raw_clk && !st.pll_q) begin
      next_st.half = !st.half;
    end
    src           = st.act_byp ? st.osc_q : st.half;
    next_st.src_q = src;
    if (src && !st.src_q) begin
      next_st.cnt = st.cnt + rsg_pkg::CNT_W'(1);
    end
    if (st.act_div == '0) begin
      next_st.sysclk = src;
    end else begin
      next_st.sysclk = st.cnt[st.act_div - rsg_pkg::DIV_W'(1)];
    end
    // Switch only with output and new source both low
    nbyp = (st.imult == rsg_pkg::IMULT_BYP);
    nsrc = nbyp ? st.osc_q : st.half;
    if (((nbyp != st.act_byp) || (st.div != st.act_div)) && !st.sysclk && !nsrc) begin
      next_st.act_byp = nbyp;
      next_st.act_div = st.div;
      next_st.cnt     = '0;
      next_st.src_q   = nsrc;
      next_st.sysclk  = 1'b0;
    end
  end

  // ****************************
  // Registers
  // ****************************
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st              <= '0;
      st.imult        <= rsg_pkg::IMULT_RST;
      st.fmult        <= rsg_pkg::FMULT_RST;
      st.div          <= rsg_pkg::DIV_RST;
      st.act_byp      <= 1'b1;
      st.act_div      <= rsg_pkg::DIV_RST;
      st.ars_oe       <= 1'b1;
      st.xrs_oe       <= 1'b1;
      st.gpio_hiz     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_awready        = st.awrdy;
  assign o_wready         = st.wrdy;
  assign o_bvalid         = st.bvalid;
  assign o_bresp          = st.bresp;
  assign o_arready        = st.arrdy;
  assign o_rvalid         = st.rvalid;
  assign o_rdata          = st.rdata;
  assign o_rresp          = st.rresp;
  assign o_ars_pin_out    = 1'b0;
  assign o_xrs_pin_out    = 1'b0;
  assign o_ars_pin_oe     = st.ars_oe;
  assign o_xrs_pin_oe     = st.xrs_oe;
  assign o_master_rst_n   = st.master_rst_n;
  assign o_control_rst_n  = st.ctrl_rst_n;
  assign o_analog_rst_n   = st.ana_rst_n;
  assign o_gpio_hiz       = st.gpio_hiz;
  assign o_lp_fast_clk    = st.lp_fast;
  assign o_lp_slow_clk    = st.lp_slow;
  assign o_mcd_ref_clk    = st.mcd_ref;
  assign o_usbpll_ref_clk = st.usb_ref;
  assign o_can_clk        = st.can_clk;
  assign o_pll_int_mult   = st.imult;
  assign o_pll_frac_mult  = st.fmult;
  assign o_pll_enable     = st.pll_en;
  assign o_sys_clk        = st.sysclk;

  // ****************************
  // Checks
  // ****************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  a_por_pins_low: assert property (!i_por_n |=> o_ars_pin_oe && o_xrs_pin_oe)
    else $error("power-on reset did not drive both pins");
  a_por_gpio_float: assert property (!i_por_n |=> o_gpio_hiz && !o_master_rst_n)
    else $error("power-on reset did not float gpio or reset master");
  a_req_and_pin: assert property ($past(i_reset_n) |-> o_xrs_pin_oe == !$past(dig_ok_n))
    else $error("digital reset pin does not follow request AND");
  a_release_hold: assert property (!st.ctrl_rel |=> !o_control_rst_n)
    else $error("control subsystem left reset without release");
  a_ext_hold_reset: assert property (!i_xrs_pin_in
                                     |=> !o_master_rst_n && !o_control_rst_n && !st.ctrl_rel)
    else $error("external pin low did not hold reset");
  a_lp_only_gate: assert property (!i_low_power |=> !o_lp_fast_clk && !o_lp_slow_clk)
    else $error("internal oscillator clock used outside low power");
  a_mcd_reference: assert property ($past(i_reset_n) |-> o_mcd_ref_clk == $past(i_fast_osc_clk))
    else $error("missing clock reference not fast oscillator");
  a_aux_routing: assert property ($past(i_reset_n)
                                  |-> o_can_clk == $past(i_aux_clk) && o_usbpll_ref_clk == o_can_clk)
    else $error("aux clock routing wrong");
  a_pll_half: assert property (i_reset_n && i_pll_raw_clk && !st.pll_q
                               |=> st.half != $past(st.half))
    else $error("raw pll clock not halved");
  a_bypass_pass: assert property (st.act_byp && st.act_div == '0 && $stable(st.act_byp)
                                  |=> o_sys_clk == $past(st.osc_q) || $changed(st.act_byp))
    else $error("bypass did not pass oscillator clock");
  a_switch_clean: assert property ($changed(st.act_byp) || $changed(st.act_div) |-> !o_sys_clk)
    else $error("clock switch during high phase");
endmodule
`default_nettype wire

/* File: bench/rsg_board.sv */
`default_nettype none
module rsg_board (
  input  wire logic i_mclk,
  input  wire logic i_ars_oe,
  input  wire logic i_xrs_oe,
  input  wire logic i_ext_hold,
  output logic      o_rst_lvl,
  output logic      o_osc,
  output logic      o_pll,
  output logic      o_fast,
  output logic      o_slow,
  output logic      o_aux
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ****************************
  // Reset wire and clock sources
  // ****************************
  // Both pins share one pulled-up trace
  assign o_rst_lvl = !(i_ars_oe || i_xrs_oe || i_ext_hold);
  initial begin
    cnt = 0;
    {o_osc, o_pll, o_fast, o_slow, o_aux} = 5'h00;
  end
  always @(posedge i_mclk) begin
    cnt <= cnt + 1;
    if (cnt % 4 == 3) o_osc <= ~o_osc;
    if (cnt % 3 == 2) o_pll <= ~o_pll;
    if (cnt % 5 == 4) o_fast <= ~o_fast;
    if (cnt % 7 == 6) o_slow <= ~o_slow;
    if (cnt % 2 == 1) o_aux <= ~o_aux;
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_reset_n, awvalid, wvalid, bready, arvalid, rready, por_n, lp, hold;
  logic [3:0] awaddr, araddr, req_n;
  logic [31:0] wdata, rd;
  logic [15:0] rnd;
  logic sys_q, pf, ps, pa, pl;
  logic awready, wready, bvalid, arready, rvalid, ars_oe, xrs_oe, rst_lvl;
  logic osc, pll, fast, slow, aux, m_rst_n, c_rst_n, a_rst_n, hiz, en, sclk;
  logic lpf, lps, mcd, usb, can;
  logic [1:0] bresp, rresp, fm;
  logic [31:0] rdata;
  logic [6:0] im;
  logic [3:0] strb;
  logic [1:0] po;
  int err_total, total_checks, edges, min_hi, hi_run, n, exp_e;
  int mdl[4];
  logic [6:0] codes[6] = '{7'h00, 7'h01, 7'h1F, 7'h20, 7'h7F, 7'h05};
  rsg_board rsg_board_i (.i_mclk(i_mclk), .i_ars_oe(ars_oe), .i_xrs_oe(xrs_oe),
    .i_ext_hold(hold), .o_rst_lvl(rst_lvl), .o_osc(osc), .o_pll(pll), .o_fast(fast),
    .o_slow(slow), .o_aux(aux));
  rsg_top rsg_top_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(strb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_por_n(por_n), .i_irqc_rst_n(req_n[0]), .i_wdog0_rst_n(req_n[1]),
    .i_wdog1_rst_n(req_n[2]), .i_nmi_wdog_rst_n(req_n[3]), .i_ars_pin_in(rst_lvl),
    .o_ars_pin_out(po[0]), .o_ars_pin_oe(ars_oe), .i_xrs_pin_in(rst_lvl),
    .o_xrs_pin_out(po[1]), .o_xrs_pin_oe(xrs_oe), .o_master_rst_n(m_rst_n),
    .o_control_rst_n(c_rst_n),
    .o_analog_rst_n(a_rst_n), .o_gpio_hiz(hiz), .i_fast_osc_clk(fast),
    .i_slow_osc_clk(slow), .i_low_power(lp), .o_lp_fast_clk(lpf), .o_lp_slow_clk(lps),
    .o_mcd_ref_clk(mcd), .i_aux_clk(aux), .o_usbpll_ref_clk(usb), .o_can_clk(can),
    .i_osc_clk(osc), .i_pll_raw_clk(pll), .o_pll_int_mult(im), .o_pll_frac_mult(fm),
    .o_pll_enable(en), .o_sys_clk(sclk));
  // ****************************
  // Clock, monitors and tasks
  // ****************************
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    sys_q <= sclk;
    if (sclk && !sys_q) edges++;
    if (sclk) hi_run++;
    else begin
      if (sys_q && hi_run < min_hi) min_hi = hi_run;
      hi_run = 0;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task complete_run;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge i_mclk);
  endtask
  task guard;
    if (++n > 500) begin
      err_total++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; n = 0;
    do begin
      @(posedge i_mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      guard();
    end while (!bvalid);
    `CHK(bresp, (a[1:0] == 2'h0) ? 2'h0 : 2'h3)
  endtask
  task rdchk(input logic [3:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; n = 0;
    do begin
      @(posedge i_mclk);
      if (arready) arvalid <= 1'b0;
      guard();
    end while (!rvalid);
    rd = rdata;
    `CHK(rresp, (a[1:0] == 2'h0) ? 2'h0 : 2'h3)
    `CHK(rd, (a[1:0] == 2'h0) ? 32'(mdl[a[3:2]]) : 32'h0000_0000)
  endtask
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, lp, hold, sys_q} = 8'h00;
    {awaddr, araddr, wdata} = '0;
    {por_n, req_n, i_reset_n} = 6'h3E;
    {err_total, total_checks, edges, hi_run} = '0;
    min_hi = 1000;
    mdl = '{0, 0, 0, 0};
    rnd = 16'h3E3E;
    strb = 4'hF;
    tick(12);
    i_reset_n <= 1'b1;
    tick(4);
    `CHK({m_rst_n, c_rst_n, a_rst_n, hiz}, 4'h8)
    for (int i = 0; i < 3; i++) rdchk(4'(i * 4));
    mdl[0] = 3;
    wr(4'h0, 32'h3);
    tick(3);
    `CHK({c_rst_n, a_rst_n}, 2'h3)
    rdchk(4'h0);
    wr(4'h6, 32'hFFFF_FFFF);
    rdchk(4'h6);
    rdchk(4'h4);
    $display("-- release test done");
    for (int i = 0; i < 14; i++) begin
      rnd = lfsr(rnd);
      mdl[1] = {rnd[9:8], 1'b0, (i < 6) ? codes[i] : rnd[6:0]};
      wr(4'h4, 32'(mdl[1]));
      tick(2);
      `CHK(im, 7'(mdl[1]))
      `CHK(fm, 2'(mdl[1] >> 8))
      `CHK(en, 1'(mdl[1][6:0] != 0))
      rdchk(4'h4);
    end
    strb <= 4'h1;
    wr(4'h4, (32'(~mdl[1]) & 32'h0000_0300) | 32'h0000_0005);
    strb <= 4'hF;
    mdl[1] = (mdl[1] & 32'h0000_0300) | 32'h0000_0005;
    rdchk(4'h4);
    $display("-- multiplier test done");
    for (int i = 0; i < 8; i++) begin
      mdl[1] = (i < 4) ? 0 : 5;
      mdl[2] = i % 4;
      wr(4'h4, 32'(mdl[1]));
      wr(4'h8, 32'(mdl[2]));
      tick(80);
      @(negedge i_mclk) edges = 0;
      tick(384);
      exp_e = ((i < 4) ? 48 : 32) >> (i % 4);
      `CHK(edges >= exp_e - 1 && edges <= exp_e + 1, 1'b1)
    end
    `CHK(min_hi >= 3, 1'b1)
    $display("-- system clock test done");
    for (int i = 0; i < 5; i++) begin
      @(posedge i_mclk);
      if (i < 4) req_n[i] <= 1'b0;
      else hold <= 1'b1;
      tick(5);
      `CHK(xrs_oe, 1'(i < 4))
      `CHK({m_rst_n, c_rst_n, a_rst_n}, 3'h0)
      req_n <= 4'hF;
      hold <= 1'b0;
      tick(8);
      `CHK({m_rst_n, c_rst_n, xrs_oe}, 3'h4)
      mdl[0] = 0;
      rdchk(4'h0);
      mdl[0] = 3;
      wr(4'h0, 32'h3);
    end
    $display("-- reset request test done");
    por_n <= 1'b0;
    tick(4);
    `CHK({ars_oe, xrs_oe, hiz, m_rst_n, c_rst_n, a_rst_n}, 6'h38)
    por_n <= 1'b1;
    tick(8);
    `CHK({hiz, m_rst_n, c_rst_n}, 3'h2)
    `CHK(po, 2'h0)
    mdl[0] = 0;
    rdchk(4'h0);
    $display("-- power-on test done");
    for (int i = 0; i < 60; i++) begin
      @(posedge i_mclk);
      {pf, ps, pa, pl} = {fast, slow, aux, lp};
      rnd = lfsr(rnd);
      lp <= rnd[0];
      @(negedge i_mclk);
      `CHK({lpf, lps}, {pf & pl, ps & pl})
      `CHK(mcd, pf)
      `CHK({usb, can}, {pa, pa})
    end
    $display("-- side clock test done");
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
